// File: core/qsfd_defines.svh
// timing and channel-count constants of the quad switch fault diagnosis controller
`ifndef QSFD_DEFINES_SVH
`define QSFD_DEFINES_SVH
// ==========================================================
// timing figures in microseconds and in clock cycles, clock rate in MHz, channel count
`define QSFD_CLK_MHZ        100
`define QSFD_TX_US          4
`define QSFD_TX_CYC         (`QSFD_TX_US * `QSFD_CLK_MHZ)
`define QSFD_TD_US          8
`define QSFD_TM_MAX_US      150
`define QSFD_WIN_US         (`QSFD_TD_US + `QSFD_TM_MAX_US)
`define QSFD_WIN_CYC        (`QSFD_WIN_US * `QSFD_CLK_MHZ)
`define QSFD_X2X_US         200
`define QSFD_X2X_CYC        (`QSFD_X2X_US * `QSFD_CLK_MHZ)
`define QSFD_SETTLE_US      90
`define QSFD_SETTLE_CYC     (`QSFD_SETTLE_US * `QSFD_CLK_MHZ)
`define QSFD_CHANNELS       4
`endif

// File: core/qsfd_pkg.sv
// types of the quad switch fault diagnosis controller
package qsfd_pkg;
  // ==========================================================
  // controller states, one-hot
  typedef enum logic [4:0] {
    QSFD_IDLE   = 5'h01,
    QSFD_SETTLE = 5'h02,
    QSFD_PULSE  = 5'h04,
    QSFD_WATCH  = 5'h08,
    QSFD_GAP    = 5'h10
  } qsfd_state_t;
  // result of a search
  typedef struct packed {
    logic       found;
    logic       none;
    logic [1:0] channel;
  } qsfd_result_t;
endpackage

// File: core/qsfd_controller.sv
// controller that locates the faulty channel of a quad high-side switch
// ==========================================================
// Notes on behaviour
// - on low flag, pulse active inputs in turn
// - interrogation pulse lasts 3 to 6 us
// - echo starts about 8 us after pulse
// - space interrogation pulses at least 200 us
// - echo in window marks the faulty channel
// - faulty channel may be switched off
`timescale 1ns/1ps
`include "qsfd_defines.svh"
module qsfd_controller #(
  parameter int unsigned TX_CYC     = `QSFD_TX_CYC,
  parameter int unsigned WIN_CYC    = `QSFD_WIN_CYC,
  parameter int unsigned X2X_CYC    = `QSFD_X2X_CYC,
  parameter int unsigned SETTLE_CYC = `QSFD_SETTLE_CYC
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // user side
  input  wire logic [3:0]          chanOn,
  input  wire logic                autoOff,
  output qsfd_pkg::qsfd_result_t   result,
  output logic                     busy,
  output logic                     done,
  // device pins
  output logic [3:0]               chanIn,
  input  wire logic                faultFlag
);
  localparam int CW = 24;
  // ==========================================================
  // pin synchroniser
  logic flagMeta;
  logic flagSync;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flagMeta <= 1'b1;
      flagSync <= 1'b1;
    end else begin
      flagMeta <= faultFlag;
      flagSync <= flagMeta;
    end
  end
  // ==========================================================
  // search sequencer
  qsfd_pkg::qsfd_state_t   state, next_state;
  logic [CW-1:0]           cnt, next_cnt;
  logic [1:0]              ch, next_ch;
  logic [3:0]              active, next_active;
  logic [3:0]              killed, next_killed;
  logic                    echo, next_echo;
  qsfd_pkg::qsfd_result_t  next_result;
  logic                    next_done;
  logic                    lastCh;
  assign lastCh = (ch == 2'h3);
  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_ch     = ch;
    next_active = active;
    next_killed = killed & chanOn;
    next_echo   = echo;
    next_result = result;
    next_done   = 1'b0;
    case (state)
      qsfd_pkg::QSFD_IDLE: begin
        if (!flagSync && (chanOn & ~killed) != 4'h0) begin
          next_state  = qsfd_pkg::QSFD_SETTLE;
          next_cnt    = '0;
          next_active = chanOn & ~killed;
        end
      end
      // let flag settle after start-up; a high flag means a false alarm
      qsfd_pkg::QSFD_SETTLE: begin
        next_cnt = cnt + 1'b1;
        if (flagSync) begin
          next_state = qsfd_pkg::QSFD_IDLE;
        end else if (cnt >= CW'(SETTLE_CYC - 1)) begin
          next_state = qsfd_pkg::QSFD_GAP;
          next_cnt   = CW'(X2X_CYC);
          next_ch    = 2'h0;
        end
      end
      qsfd_pkg::QSFD_PULSE: begin
        next_cnt = cnt + 1'b1;
        if (cnt >= CW'(TX_CYC - 1)) begin
          next_state = qsfd_pkg::QSFD_WATCH;
          next_cnt   = '0;
          next_echo  = 1'b0;
        end
      end
      // window covers echo delay plus longest echo
      qsfd_pkg::QSFD_WATCH: begin
        next_cnt = cnt + 1'b1;
        if (flagSync) begin
          next_echo = 1'b1;
        end
        if (cnt >= CW'(WIN_CYC - 1)) begin
          next_state = qsfd_pkg::QSFD_GAP;
          if (echo || flagSync) begin
            next_result.found   = 1'b1;
            next_result.none    = 1'b0;
            next_result.channel = ch;
            next_done           = 1'b1;
            next_state          = qsfd_pkg::QSFD_IDLE;
            if (autoOff) begin
              next_killed[ch] = 1'b1;
            end
          end else if (lastCh) begin
            next_result.found = 1'b0;
            next_result.none  = 1'b1;
            next_done         = 1'b1;
            next_state        = qsfd_pkg::QSFD_IDLE;
          end else begin
            next_ch = ch + 2'h1;
          end
        end
      end
      // gap then pick next active channel
      qsfd_pkg::QSFD_GAP: begin
        next_cnt = cnt + 1'b1;
        if (cnt >= CW'(X2X_CYC - TX_CYC - 1)) begin
          if (active[ch]) begin
            next_state = qsfd_pkg::QSFD_PULSE;
            next_cnt   = '0;
          end else if (lastCh) begin
            next_result.found = 1'b0;
            next_result.none  = 1'b1;
            next_done         = 1'b1;
            next_state        = qsfd_pkg::QSFD_IDLE;
          end else begin
            next_ch = ch + 2'h1;
          end
        end
      end
      default: begin
        next_state = qsfd_pkg::QSFD_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state  <= qsfd_pkg::QSFD_IDLE;
      cnt    <= '0;
      ch     <= 2'h0;
      active <= 4'h0;
      killed <= 4'h0;
      echo   <= 1'b0;
      result <= '0;
      done   <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      ch     <= next_ch;
      active <= next_active;
      killed <= next_killed;
      echo   <= next_echo;
      result <= next_result;
      done   <= next_done;
    end
  end
  // ==========================================================
  // pin drive, registered so pulses are glitch free
  logic [3:0] next_chanIn;
  always_comb begin
    next_chanIn = chanOn & ~next_killed;
    if (next_state == qsfd_pkg::QSFD_PULSE) begin
      next_chanIn[next_ch] = 1'b0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chanIn <= 4'h0;
    end else begin
      chanIn <= next_chanIn;
    end
  end
  assign busy = (state != qsfd_pkg::QSFD_IDLE);
  // ==========================================================
  // checks
  property p_pulse_len;
    @(posedge clk) disable iff (rst)
      $rose(state == qsfd_pkg::QSFD_PULSE) |->
        (state == qsfd_pkg::QSFD_PULSE)[*8] ##[1:600] (state == qsfd_pkg::QSFD_WATCH);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
  property p_pulse_low;
    @(posedge clk) disable iff (rst)
      (state == qsfd_pkg::QSFD_PULSE) |=> !chanIn[ch] || state != qsfd_pkg::QSFD_PULSE;
  endproperty
  a_pulse_low: assert property (p_pulse_low) else $error("pulse not low");
  property p_gap;
    @(posedge clk) disable iff (rst)
      $fell(state == qsfd_pkg::QSFD_PULSE) |-> (state != qsfd_pkg::QSFD_PULSE)[*8];
  endproperty
  a_gap: assert property (p_gap) else $error("pulses too close");
  property p_echo;
    @(posedge clk) disable iff (rst)
      (state == qsfd_pkg::QSFD_WATCH && flagSync) |=> echo;
  endproperty
  a_echo: assert property (p_echo) else $error("echo missed");
  property p_kill;
    @(posedge clk) disable iff (rst)
      (done && result.found && autoOff && $past(autoOff)) |=> !chanIn[result.channel];
  endproperty
  a_kill: assert property (p_kill) else $error("faulty channel not off");
  property p_start;
    @(posedge clk) disable iff (rst)
      (state == qsfd_pkg::QSFD_IDLE && !flagSync && (chanOn & ~killed) != 4'h0)
        |=> state == qsfd_pkg::QSFD_SETTLE;
  endproperty
  a_start: assert property (p_start) else $error("search not started");
  property p_done_pulse;
    @(posedge clk) disable iff (rst) done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_watch_exit;
    @(posedge clk) disable iff (rst)
      (state == qsfd_pkg::QSFD_WATCH && cnt == CW'(WIN_CYC - 1)) |=> state != qsfd_pkg::QSFD_WATCH;
  endproperty
  a_watch_exit: assert property (p_watch_exit) else $error("window overrun");
endmodule

// File: bench/qsfd_switch_model.sv
// behavioural model of the quad high-side switch status logic
`timescale 1ns/1ps
module qsfd_switch_model #(
  parameter int HOLD   = 12,
  parameter int SETTLE = 5,
  parameter int TD     = 2,
  parameter int TM     = 10
) (
  // tick and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // channel inputs and injected faults
  input  wire logic [3:0] chanIn,
  input  wire logic [3:0] overload,
  input  wire logic [3:0] overTemp,
  // open-drain flag as seen behind the pull-up
  output logic            faultFlag
);
  // ==========================================================
  // state, counted in clock ticks
  int         lowCnt [4];
  int         setCnt;
  int         echoCnt;
  logic [3:0] outOn;
  logic       faultNow;
  // short low pulses are filtered so the output never blinks
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      outOn[i] = (chanIn[i] | (lowCnt[i] < HOLD)) & ~overTemp[i];
    end
    faultNow = (|(outOn & overload)) | (|overTemp);
  end
  // settle, low-time and echo counters
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      setCnt  <= 0;
      echoCnt <= 0;
      lowCnt  <= '{default: HOLD};
    end else begin
      setCnt <= faultNow ? setCnt + int'(setCnt < SETTLE) : 0;
      if (echoCnt > 0) echoCnt <= echoCnt - 1;
      for (int i = 0; i < 4; i++) begin
        lowCnt[i] <= chanIn[i] ? 0 : lowCnt[i] + int'(lowCnt[i] < HOLD);
        // only a faulty channel answers, after a short delay
        if (chanIn[i] && lowCnt[i] > 0 && lowCnt[i] < HOLD && (overload[i] | overTemp[i]))
          echoCnt <= TD + TM;
      end
    end
  end
  // released (high) unless settled fault and no echo
  assign faultFlag = (setCnt != SETTLE) || (echoCnt > 0 && echoCnt <= TM);
endmodule

// File: bench/tb_qsfd_controller.sv
// self-checking bench of the fault diagnosis controller
`timescale 1ns/1ps
module tb_qsfd_controller;
  localparam int TX = 8;
  localparam int X2X = 60;
  logic                   clk, rst, autoOff, faultFlag, busy, done;
  logic [3:0]             chanOn, chanIn, overload, overTemp, prevIn, on;
  qsfd_pkg::qsfd_result_t result;
  int                     err_total, total_checks, cyc, lastStart, fallAt [4];
  // $random wants a four-state integer as its seed variable
  integer                 seed;
  logic [1:0]             f;
  qsfd_controller #(.TX_CYC(TX), .WIN_CYC(40), .X2X_CYC(X2X), .SETTLE_CYC(20))
    i_qsfd_controller (.clk(clk), .rst(rst), .chanOn(chanOn), .autoOff(autoOff),
    .result(result), .busy(busy), .done(done), .chanIn(chanIn), .faultFlag(faultFlag));
  qsfd_switch_model i_qsfd_switch_model (.clk(clk), .rst(rst), .chanIn(chanIn),
    .overload(overload), .overTemp(overTemp), .faultFlag(faultFlag));
  // ==========================================================
  // compare and report
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // lowest active faulty channel, since channels are tried upwards
  function automatic logic [3:0] expect_res(input logic [3:0] act, input logic [3:0] bad);
    for (int i = 0; i < 4; i++) if (act[i] && bad[i]) return {2'b10, 2'(i)};
    return 4'b0100;
  endfunction
  // one fault, one search, then clear the faults and the channel enables
  task automatic search(input logic [3:0] act, input logic [3:0] ovl, input logic [3:0] ot,
                        input logic ao);
    int         n;
    logic [3:0] exp;
    exp = expect_res(act, ovl | ot);
    @(posedge clk);
    chanOn   <= act;
    autoOff  <= ao;
    overload <= ovl;
    overTemp <= ot;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (done !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      err_total++;
      conclude();
    end
    check({6'h0, result.found, result.none}, {6'h0, exp[3:2]});
    if (exp[3]) check({6'h0, result.channel}, {6'h0, exp[1:0]});
    repeat (3) @(posedge clk);
    #1 check({4'h0, chanIn}, {4'h0, act & ~((ao & exp[3]) ? 4'h1 << exp[1:0] : 4'h0)});
    @(posedge clk);
    overload <= 4'h0;
    overTemp <= 4'h0;
    chanOn   <= 4'h0;
    repeat (30) @(posedge clk);
    #1 check({7'h0, busy}, 8'h00);
  endtask
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // pulse width and spacing on the device inputs
  always @(posedge clk) begin
    cyc++;
    for (int i = 0; i < 4; i++) begin
      if (!chanOn[i] || rst) fallAt[i] = -1;
      else if (prevIn[i] && !chanIn[i]) fallAt[i] = cyc;
      else if (!prevIn[i] && chanIn[i] && fallAt[i] >= 0) begin
        check(8'(cyc - fallAt[i]), 8'(TX));
        check({7'h0, fallAt[i] - lastStart >= X2X}, 8'h01);
        lastStart = fallAt[i];
      end
    end
    prevIn = chanIn;
  end
  // corner cases first, then random faults
  initial begin
    seed = 66985;
    lastStart = -100000;
    rst = 1'b1;
    chanOn = 4'h0;
    autoOff = 1'b0;
    overload = 4'h0;
    overTemp = 4'h0;
    // reset spans four rising edges, released on the fourth
    repeat (3) @(posedge clk);
    #1 check({4'h0, chanIn}, 8'h00);
    @(posedge clk);
    rst <= 1'b0;
    search(4'hf, 4'h8, 4'h0, 1'b1);
    search(4'h3, 4'h0, 4'h8, 1'b0);
    search(4'h5, 4'h0, 4'h4, 1'b1);
    search(4'hf, 4'h1, 4'h0, 1'b0);
    repeat (12) begin
      on = 4'($random(seed)) | 4'h1;
      f = 2'($random(seed));
      while (!on[f]) f = f + 2'h1;
      if ($random(seed) & 1) search(on, 4'h1 << f, 4'h0, 1'($random(seed)));
      else search(on, 4'h0, 4'h1 << f, 1'($random(seed)));
    end
    conclude();
  end
endmodule
